// file: verilog/rul_cfg.svh
// constants of the remote update configuration loader
// assumes inclusion by bare name from the loader's design files
`ifndef RUL_CFG_SVH
`define RUL_CFG_SVH

`define RUL_PAGE_W 3
`define RUL_FACTORY_PAGE 3'h0
`define RUL_LOCAL_PAGE 3'h1
`define RUL_CTRL_PAGE_RST 3'h1
`define RUL_INIT_CYC 4'h8
`define RUL_BYTE_W 8
`define RUL_PLL_CNT_W 8
`define RUL_PLL_CHAIN_W 24
`define RUL_WDT_SEL_W 2
`define RUL_WDT_CNT_W 16
`define RUL_WDT_BASE_CYC 16'h1000
`define RUL_CAUSE_W 4
`define RUL_CAUSE_PIN 0
`define RUL_CAUSE_WDT 1
`define RUL_CAUSE_ERR 2
`define RUL_CAUSE_USER 3

`endif

// file: verilog/rul_pkg.sv
// types of the remote update configuration loader
// assumes nothing of its surroundings
package rul_pkg;

    typedef enum logic [2:0] {
        RUL_SCH_CFG_MEMORY,
        RUL_SCH_SERIAL_PASSIVE_SCHEME,
        RUL_SCH_PARALLEL_ASYNC_SCHEME,
        RUL_SCH_FAST_PARALLEL,
        RUL_SCH_BOUNDARY_SCAN
    } rul_scheme_t;

    typedef enum logic [1:0] {
        RUL_ST_WAIT,
        RUL_ST_LOAD,
        RUL_ST_INIT,
        RUL_ST_USER
    } rul_state_t;

endpackage : rul_pkg

// file: verilog/rul_wdt_if.sv
// watchdog control bundle between loader core and watchdog
// assumes one clock shared by both ends
`timescale 1ns/1ps
`include "rul_cfg.svh"

interface rul_wdt_if;
    logic enable;
    logic kick;
    logic [`RUL_WDT_SEL_W-1:0] sel;
    logic expire;

    modport ctl (output enable, output kick, output sel, input expire);
    modport wdt (input enable, input kick, input sel, output expire);
endinterface : rul_wdt_if

// file: verilog/rul_watchdog.sv
// user watchdog: counts while enabled, pulses expire on timeout
// assumes enable drops whenever the factory image runs
`timescale 1ns/1ps
`include "rul_cfg.svh"

module rul_watchdog #(
    parameter int WDT_BASE_CYC = `RUL_WDT_BASE_CYC
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // control bundle
    rul_wdt_if.wdt bus
);

    logic [`RUL_WDT_CNT_W-1:0] cnt_r;
    logic expire_r;
    wire [`RUL_WDT_CNT_W-1:0] limit;
    wire hit;

    assign limit = `RUL_WDT_CNT_W'(WDT_BASE_CYC) << bus.sel;
    assign hit = (cnt_r == limit - `RUL_WDT_CNT_W'(1));
    assign bus.expire = expire_r;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_r <= '0;
            expire_r <= 1'b0;
        end else if (!bus.enable || bus.kick || hit) begin
            cnt_r <= '0;
            expire_r <= bus.enable && !bus.kick && hit;
        end else begin
            cnt_r <= cnt_r + `RUL_WDT_CNT_W'(1);
            expire_r <= 1'b0;
        end
    end

    // [RQ10] restart clears count
    AST_WDT_KICK: assert property (@(posedge clk_i) disable iff (rst_i)
        bus.kick |=> cnt_r == '0 && !expire_r) // [RQ10]
        else $error("watchdog not cleared by restart");

    // [RQ12] no expiry when disabled
    AST_WDT_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
        !bus.enable |=> !expire_r) // [RQ12]
        else $error("watchdog expired while disabled");

endmodule : rul_watchdog

// file: verilog/rul_loader.sv
// remote update configuration loader: boot, page selection, watchdog
// assumes the memory or host streams the page shown on page_o
//
// Behaviour
// [RQ1] user I/O stays high impedance until configuration completes
// [RQ2] after loading, an init phase resets logic then enables I/O
// [RQ3] the reconfiguration pin forces command mode and a full reload
// [RQ4] a load waits for chain enable in; chain enable out follows
// [RQ5] data accepted in five schemes, serial ones assembled to bytes
// [RQ6] first remote mode power-up loads page zero
// [RQ7] the factory image at page zero is never overwritten outside
// [RQ8] the factory image writes the next page into control
// [RQ9] the factory image chooses watchdog enable and timeout
// [RQ10] the application restarts the watchdog before timeout
// [RQ11] watchdog expiry records status then reloads factory
// [RQ12] watchdog is disabled while the factory image runs
// [RQ13] a load error records cause then loads the factory image
// [RQ14] the factory image reads status, then writes control
// [RQ15] an application loaded cleanly enters user mode
// [RQ16] at most seven application pages plus the factory page
// [RQ17] application logic may trigger a factory reload after update
// [RQ18] remote update works serial, sync and async parallel
// [RQ19] local update loads the single application at power-up
// [RQ20] PLL counters reload by serial chain while device runs
// [RQ21] page field is three bits, zero is factory
`timescale 1ns/1ps
`include "rul_cfg.svh"

module rul_loader #(
    parameter int WDT_BASE_CYC = `RUL_WDT_BASE_CYC
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // straps and pins
    input wire logic remote_mode_i,
    input wire logic [2:0] scheme_i,
    input wire logic reconfig_i,
    input wire logic chain_enable_in_n_i,
    output logic chain_enable_out_n_o,
    // configuration data stream
    input wire logic cfg_valid_i,
    input wire logic [`RUL_BYTE_W-1:0] cfg_data_i,
    input wire logic cfg_last_i,
    input wire logic cfg_error_i,
    output logic cfg_ready_o,
    output logic [`RUL_PAGE_W-1:0] page_o,
    output logic [`RUL_BYTE_W-1:0] sram_data_o,
    output logic sram_valid_o,
    // device mode
    output logic io_oe_o,
    output logic user_rst_o,
    output logic user_mode_o,
    output logic factory_o,
    // control from and status to user logic
    input wire logic ctrl_wr_i,
    input wire logic [`RUL_PAGE_W-1:0] ctrl_page_i,
    input wire logic ctrl_wdt_en_i,
    input wire logic [`RUL_WDT_SEL_W-1:0] ctrl_wdt_sel_i,
    input wire logic wdt_kick_i,
    input wire logic update_trigger_i,
    output logic [`RUL_CAUSE_W-1:0] status_cause_o,
    output logic [`RUL_PAGE_W-1:0] status_page_o,
    // pll counter chain
    input wire logic pll_shift_i,
    input wire logic pll_sdata_i,
    input wire logic pll_update_i,
    output logic [`RUL_PLL_CNT_W-1:0] pll_mult_o,
    output logic [`RUL_PLL_CNT_W-1:0] pll_div_o,
    output logic [`RUL_PLL_CNT_W-1:0] pll_delay_o
);

    rul_pkg::rul_state_t state_r;
    rul_pkg::rul_state_t state_nxt;
    rul_pkg::rul_scheme_t scheme_r;
    logic first_r;
    logic remote_r;
    logic [`RUL_PAGE_W-1:0] page_r;
    logic [`RUL_PAGE_W-1:0] page_nxt;
    logic [3:0] init_cnt_r;
    logic [`RUL_BYTE_W-1:0] sh_r;
    logic [2:0] bit_cnt_r;
    logic [`RUL_BYTE_W-1:0] byte_r;
    logic byte_vld_r;
    logic ready_r;
    logic io_oe_r;
    logic user_rst_r;
    logic ceo_n_r;
    logic factory_r;
    logic [`RUL_CAUSE_W-1:0] cause_r;
    logic [`RUL_PAGE_W-1:0] stat_page_r;
    logic [`RUL_PAGE_W-1:0] ctrl_page_r;
    logic ctrl_wdt_en_r;
    logic [`RUL_WDT_SEL_W-1:0] ctrl_wdt_sel_r;
    logic wdt_cfg_en_r;
    logic [`RUL_WDT_SEL_W-1:0] wdt_cfg_sel_r;
    logic wdt_en_r;
    logic [`RUL_PLL_CHAIN_W-1:0] pll_sh_r;
    logic [`RUL_PLL_CNT_W-1:0] pll_mult_r;
    logic [`RUL_PLL_CNT_W-1:0] pll_div_r;
    logic [`RUL_PLL_CNT_W-1:0] pll_delay_r;

    rul_wdt_if wdt_bus();

    rul_watchdog #(
        .WDT_BASE_CYC(WDT_BASE_CYC)
    ) u_wdt (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .bus(wdt_bus.wdt)
    );

    // decode
    wire wait_st = (state_r == rul_pkg::RUL_ST_WAIT);
    wire load_st = (state_r == rul_pkg::RUL_ST_LOAD);
    wire init_st = (state_r == rul_pkg::RUL_ST_INIT);
    wire user_st = (state_r == rul_pkg::RUL_ST_USER);
    wire is_factory = (page_r == `RUL_FACTORY_PAGE);
    wire start = wait_st && !chain_enable_in_n_i;
    wire pin_evt = reconfig_i && !wait_st;
    wire err_evt = load_st && cfg_error_i && !pin_evt;
    wire wdt_evt = user_st && wdt_bus.expire && !pin_evt;
    wire trg_evt = user_st && update_trigger_i && !pin_evt
        && !wdt_bus.expire;
    wire reboot = pin_evt || err_evt || wdt_evt || trg_evt;
    wire accept = load_st && cfg_valid_i && ready_r && !reboot;
    wire serial = (scheme_r == rul_pkg::RUL_SCH_CFG_MEMORY)
        || (scheme_r == rul_pkg::RUL_SCH_SERIAL_PASSIVE_SCHEME)
        || (scheme_r == rul_pkg::RUL_SCH_BOUNDARY_SCAN);
    wire [`RUL_BYTE_W-1:0] sh_nxt = {cfg_data_i[0], sh_r[7:1]};
    wire app_next = (page_nxt != `RUL_FACTORY_PAGE);
    wire ctrl_wen = ctrl_wr_i && user_st && is_factory && remote_r;
    // [RQ8] factory selects next page
    wire [`RUL_PAGE_W-1:0] app_pick = is_factory ? ctrl_page_r
        : `RUL_FACTORY_PAGE;
    // [RQ6] [RQ19] strap picks first page
    wire [`RUL_PAGE_W-1:0] strap_page = remote_mode_i
        ? `RUL_FACTORY_PAGE : `RUL_LOCAL_PAGE;

    // [RQ3] pin and trigger reload
    always_comb begin
        page_nxt = page_r;
        if (reboot) begin
            if (!remote_r)
                page_nxt = `RUL_LOCAL_PAGE;
            else if (pin_evt || trg_evt)
                page_nxt = app_pick;
            else
                page_nxt = `RUL_FACTORY_PAGE;
        end else if (start && first_r) begin
            page_nxt = strap_page;
        end
    end

    // [RQ15] clean load runs image
    always_comb begin
        state_nxt = state_r;
        if (reboot) begin
            state_nxt = rul_pkg::RUL_ST_WAIT;
        end else begin
            case (state_r)
                rul_pkg::RUL_ST_WAIT: begin
                    if (start)
                        state_nxt = rul_pkg::RUL_ST_LOAD;
                end
                rul_pkg::RUL_ST_LOAD: begin
                    if (accept && cfg_last_i)
                        state_nxt = rul_pkg::RUL_ST_INIT;
                end
                rul_pkg::RUL_ST_INIT: begin
                    if (init_cnt_r == 4'h0)
                        state_nxt = rul_pkg::RUL_ST_USER;
                end
                rul_pkg::RUL_ST_USER: begin
                    state_nxt = rul_pkg::RUL_ST_USER;
                end
                default: begin
                    state_nxt = rul_pkg::RUL_ST_WAIT;
                end
            endcase
        end
    end

    // [RQ4] chain gating and mode
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_r <= rul_pkg::RUL_ST_WAIT;
            page_r <= `RUL_FACTORY_PAGE;
            first_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            page_r <= page_nxt;
            if (start)
                first_r <= 1'b0;
        end
    end

    // strap capture: mode at first load, scheme at every load
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            remote_r <= 1'b1;
            scheme_r <= rul_pkg::RUL_SCH_CFG_MEMORY;
        end else if (start) begin
            if (first_r)
                remote_r <= remote_mode_i;
            scheme_r <= rul_pkg::rul_scheme_t'(scheme_i);
        end
    end

    // [RQ1] pins high-z until user
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            io_oe_r <= 1'b0;
            user_rst_r <= 1'b1;
            ceo_n_r <= 1'b1;
            ready_r <= 1'b0;
            factory_r <= 1'b0;
        end else begin
            factory_r <= (state_nxt == rul_pkg::RUL_ST_USER)
                && (page_nxt == `RUL_FACTORY_PAGE);
            io_oe_r <= (state_nxt == rul_pkg::RUL_ST_USER);
            user_rst_r <= (state_nxt != rul_pkg::RUL_ST_USER);
            ceo_n_r <= (state_nxt != rul_pkg::RUL_ST_USER)
                && (state_nxt != rul_pkg::RUL_ST_INIT);
            ready_r <= (state_nxt == rul_pkg::RUL_ST_LOAD);
        end
    end

    // [RQ2] init phase count
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i)
            init_cnt_r <= 4'h0;
        else if (!init_st)
            init_cnt_r <= `RUL_INIT_CYC - 4'h1;
        else
            init_cnt_r <= init_cnt_r - 4'h1;
    end

    // [RQ5] [RQ18] scheme data assembly
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sh_r <= '0;
            bit_cnt_r <= 3'h0;
            byte_r <= '0;
            byte_vld_r <= 1'b0;
        end else begin
            byte_vld_r <= accept && (!serial || bit_cnt_r == 3'h7);
            if (!load_st) begin
                bit_cnt_r <= 3'h0;
            end else if (accept && serial) begin
                sh_r <= sh_nxt;
                bit_cnt_r <= bit_cnt_r + 3'h1;
                byte_r <= sh_nxt;
            end else if (accept) begin
                byte_r <= cfg_data_i;
            end
        end
    end

    // [RQ13] [RQ11] status on reboot
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cause_r <= '0;
            stat_page_r <= `RUL_FACTORY_PAGE;
        end else if (reboot) begin
            cause_r <= {trg_evt, err_evt, wdt_evt, pin_evt};
            stat_page_r <= page_r;
        end
    end

    // [RQ9] [RQ16] [RQ21] control register
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_page_r <= `RUL_CTRL_PAGE_RST;
            ctrl_wdt_en_r <= 1'b0;
            ctrl_wdt_sel_r <= '0;
        end else if (ctrl_wen) begin
            ctrl_page_r <= ctrl_page_i;
            ctrl_wdt_en_r <= ctrl_wdt_en_i;
            ctrl_wdt_sel_r <= ctrl_wdt_sel_i;
        end
    end

    // [RQ12] watchdog off for factory
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wdt_cfg_en_r <= 1'b0;
            wdt_cfg_sel_r <= '0;
            wdt_en_r <= 1'b0;
        end else begin
            if (reboot) begin
                wdt_cfg_en_r <= remote_r && app_next && ctrl_wdt_en_r;
                wdt_cfg_sel_r <= ctrl_wdt_sel_r;
            end
            wdt_en_r <= (state_nxt == rul_pkg::RUL_ST_USER)
                && (page_nxt != `RUL_FACTORY_PAGE) && wdt_cfg_en_r;
        end
    end

    assign wdt_bus.enable = wdt_en_r;
    assign wdt_bus.kick = wdt_kick_i;
    assign wdt_bus.sel = wdt_cfg_sel_r;

    // [RQ20] pll chain reload
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pll_sh_r <= '0;
            pll_mult_r <= '0;
            pll_div_r <= '0;
            pll_delay_r <= '0;
        end else begin
            if (pll_shift_i)
                pll_sh_r <= {pll_sh_r[`RUL_PLL_CHAIN_W-2:0], pll_sdata_i};
            if (pll_update_i) begin
                pll_mult_r <= pll_sh_r[23:16];
                pll_div_r <= pll_sh_r[15:8];
                pll_delay_r <= pll_sh_r[7:0];
            end
        end
    end

    assign chain_enable_out_n_o = ceo_n_r;
    assign cfg_ready_o = ready_r;
    assign page_o = page_r;
    assign sram_data_o = byte_r;
    assign sram_valid_o = byte_vld_r;
    assign io_oe_o = io_oe_r;
    assign user_rst_o = user_rst_r;
    assign user_mode_o = io_oe_r;
    assign factory_o = factory_r;
    assign status_cause_o = cause_r;
    assign status_page_o = stat_page_r;
    assign pll_mult_o = pll_mult_r;
    assign pll_div_o = pll_div_r;
    assign pll_delay_o = pll_delay_r;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_IO_HIZ: assert property (!user_st |-> !io_oe_o) // [RQ1]
        else $error("io enabled outside user mode");

    AST_INIT_LEN: assert property ( // [RQ2]
        ($rose(init_st) && !reconfig_i) |-> (init_st && user_rst_o)[*8]
        ##1 (user_st || $past(reconfig_i)))
        else $error("init phase length wrong");

    AST_PIN_RELOAD: assert property ( // [RQ3]
        (user_st && reconfig_i) |=> wait_st && !io_oe_o && user_rst_o)
        else $error("pin did not force command mode");

    AST_CHAIN_WAIT: assert property ( // [RQ4]
        (wait_st && chain_enable_in_n_i) |=> wait_st && chain_enable_out_n_o)
        else $error("load started without chain enable");

    AST_FIRST_PAGE: assert property ( // [RQ6]
        (start && first_r && remote_mode_i) |=> page_o == 3'h0 && load_st)
        else $error("first remote boot not page zero");

    AST_WDT_STATUS: assert property ( // [RQ11]
        wdt_evt |=> status_cause_o[`RUL_CAUSE_WDT] && page_o == 3'h0
        ##1 !io_oe_o)
        else $error("watchdog expiry not handled");

    AST_WDT_FACTORY: assert property ( // [RQ12]
        factory_o |-> !wdt_bus.enable)
        else $error("watchdog enabled in factory image");

    AST_LOAD_ERR: assert property ( // [RQ13]
        err_evt && remote_r |=> status_cause_o[`RUL_CAUSE_ERR]
        && page_o == 3'h0 && status_page_o == $past(page_r))
        else $error("load error not recorded");

    AST_LOCAL_BOOT: assert property ( // [RQ19]
        (start && first_r && !remote_mode_i) |=> page_o == 3'h1)
        else $error("local boot did not load application");

    AST_PLL_LOAD: assert property ( // [RQ20]
        pll_update_i |=> pll_mult_o == $past(pll_sh_r[23:16])
        && pll_delay_o == $past(pll_sh_r[7:0]))
        else $error("pll counters not reloaded");

endmodule : rul_loader

// file: test/rul_mem_model.sv
// configuration memory model: streams the requested page
// assumes the loader holds ready high for the whole load
`timescale 1ns/1ps

module rul_mem_model #(
    parameter int NB = 3
) (
    // clock
    input wire logic clk_i,
    // from loader, plus the scheme strap
    input wire logic ready_i,
    input wire logic [2:0] page_i,
    input wire logic [2:0] scheme_i,
    // scenario control
    input wire logic slow_i,
    input wire logic [3:0] err_page_i,
    // to loader
    output logic valid_o = 1'b0,
    output logic [7:0] data_o = 8'h00,
    output logic last_o = 1'b0,
    output logic error_o = 1'b0
);
    int idx = 0;
    int tot;
    logic gap = 1'b0;
    logic ser;
    logic [7:0] cur;

    assign ser = scheme_i == 3'h0 || scheme_i == 3'h1 || scheme_i == 3'h4;
    assign tot = ser ? NB * 8 : NB;

    // count beats the loader took
    always @(posedge clk_i) begin
        if (ready_i !== 1'b1)
            idx <= 0;
        else if (valid_o)
            idx <= idx + 1;
    end

    always @(negedge clk_i) begin
        gap = ~gap;
        cur = {1'b1, page_i, 4'(ser ? idx / 8 : idx)};
        valid_o = 1'b0;
        last_o = 1'b0;
        error_o = 1'b0;
        data_o = ~data_o;
        if (ready_i === 1'b1 && idx < tot && !(slow_i && gap)) begin
            if ({1'b0, page_i} == err_page_i && idx == 1)
                error_o = 1'b1;
            else begin
                valid_o = 1'b1;
                last_o = idx == tot - 1;
                data_o = ser ? {data_o[7:1], cur[idx % 8]} : cur;
            end
        end
    end
endmodule : rul_mem_model

// file: test/remote_update_config_loader_test.sv
// self-checking bench of the configuration loader
// assumes the memory model stands on the data stream
`timescale 1ns/1ps
`include "rul_cfg.svh"

module remote_update_config_loader_test;
    localparam int NB = 3;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic remote_mode_i = 1'b1;
    logic [2:0] scheme_i = 3'h0;
    logic reconfig_i = 1'b0;
    logic chain_enable_in_n_i = 1'b1;
    logic ctrl_wr_i = 1'b0;
    logic [2:0] ctrl_page_i = 3'h0;
    logic ctrl_wdt_en_i = 1'b0;
    logic [1:0] ctrl_wdt_sel_i = 2'h0;
    logic wdt_kick_i = 1'b0;
    logic update_trigger_i = 1'b0;
    logic pll_shift_i = 1'b0;
    logic pll_sdata_i = 1'b0;
    logic pll_update_i = 1'b0;
    logic slow = 1'b0;
    logic [3:0] err_page = 4'hF;
    logic cfg_valid_i, cfg_last_i, cfg_error_i, cfg_ready_o;
    logic [7:0] cfg_data_i, sram_data_o, pll_mult_o, pll_div_o, pll_delay_o;
    logic [2:0] page_o, status_page_o;
    logic [3:0] status_cause_o;
    logic chain_enable_out_n_o, sram_valid_o, io_oe_o, user_rst_o;
    logic user_mode_o, factory_o;
    int bad_count = 0;
    int cmp_count = 0;
    int n_bytes = 0;
    logic [7:0] last_byte = 8'h00;

    rul_loader #(.WDT_BASE_CYC(8)) uut (.clk_i(clk_i), .rst_i(rst_i),
        .remote_mode_i(remote_mode_i), .scheme_i(scheme_i),
        .reconfig_i(reconfig_i), .chain_enable_in_n_i(chain_enable_in_n_i),
        .chain_enable_out_n_o(chain_enable_out_n_o),
        .cfg_valid_i(cfg_valid_i), .cfg_data_i(cfg_data_i),
        .cfg_last_i(cfg_last_i), .cfg_error_i(cfg_error_i),
        .cfg_ready_o(cfg_ready_o), .page_o(page_o),
        .sram_data_o(sram_data_o), .sram_valid_o(sram_valid_o),
        .io_oe_o(io_oe_o), .user_rst_o(user_rst_o),
        .user_mode_o(user_mode_o), .factory_o(factory_o),
        .ctrl_wr_i(ctrl_wr_i), .ctrl_page_i(ctrl_page_i),
        .ctrl_wdt_en_i(ctrl_wdt_en_i), .ctrl_wdt_sel_i(ctrl_wdt_sel_i),
        .wdt_kick_i(wdt_kick_i), .update_trigger_i(update_trigger_i),
        .status_cause_o(status_cause_o), .status_page_o(status_page_o),
        .pll_shift_i(pll_shift_i), .pll_sdata_i(pll_sdata_i),
        .pll_update_i(pll_update_i), .pll_mult_o(pll_mult_o),
        .pll_div_o(pll_div_o), .pll_delay_o(pll_delay_o));

    rul_mem_model #(.NB(NB)) mem (.clk_i(clk_i), .ready_i(cfg_ready_o),
        .page_i(page_o), .scheme_i(scheme_i), .slow_i(slow),
        .err_page_i(err_page), .valid_o(cfg_valid_i), .data_o(cfg_data_i),
        .last_o(cfg_last_i), .error_o(cfg_error_i));

    initial begin
        forever #2 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        if (sram_valid_o === 1'b1) begin
            n_bytes <= n_bytes + 1;
            last_byte <= sram_data_o;
        end
    end

    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr_ctrl(input logic [2:0] pg, input logic en,
                           input logic [1:0] sel);
        @(negedge clk_i);
        ctrl_wr_i = 1'b1;
        ctrl_page_i = pg;
        ctrl_wdt_en_i = en;
        ctrl_wdt_sel_i = sel;
        @(negedge clk_i);
        ctrl_wr_i = 1'b0;
    endtask : wr_ctrl

    task automatic fire(input logic pin);
        @(negedge clk_i);
        if (pin)
            reconfig_i = 1'b1;
        else
            update_trigger_i = 1'b1;
        @(negedge clk_i);
        reconfig_i = 1'b0;
        update_trigger_i = 1'b0;
    endtask : fire

    task automatic reboot(input logic [3:0] cs, input logic [2:0] sp,
                          input logic [2:0] np);
        @(negedge clk_i);
        chk("io_oe_o", 8'h00, {7'h00, io_oe_o});
        chk("status_cause_o", {4'h0, cs}, {4'h0, status_cause_o});
        chk("status_page_o", {5'h00, sp}, {5'h00, status_page_o});
        chk("page_o", {5'h00, np}, {5'h00, page_o});
    endtask : reboot

    task automatic to_user(input logic [2:0] pg);
        int n;
        int b0;
        n = 0;
        b0 = n_bytes;
        while (cfg_ready_o !== 1'b1 && n < 100) begin
            @(negedge clk_i);
            n++;
        end
        chk("cfg_ready_o", 8'h01, {7'h00, cfg_ready_o});
        chk("page_o", {5'h00, pg}, {5'h00, page_o});
        chk("io_oe_o", 8'h00, {7'h00, io_oe_o});
        n = 0;
        while (cfg_ready_o === 1'b1 && n < 400) begin
            @(negedge clk_i);
            n++;
        end
        n = 0;
        while (io_oe_o !== 1'b1 && n < 50) begin
            @(negedge clk_i);
            n++;
        end
        chk("init cycles", {4'h0, `RUL_INIT_CYC}, n[7:0]);
        chk("user_rst_o", 8'h00, {7'h00, user_rst_o});
        chk("user_mode_o", 8'h01, {7'h00, user_mode_o});
        chk("ceo_n", 8'h00, {7'h00, chain_enable_out_n_o});
        b0 = n_bytes - b0;
        chk("bytes", NB[7:0], b0[7:0]);
        chk("last byte", {1'b1, pg, 4'h2}, last_byte);
    endtask : to_user

    task automatic pll_load(input logic [23:0] v);
        for (int i = 23; i >= 0; i--) begin
            @(negedge clk_i);
            pll_shift_i = 1'b1;
            pll_sdata_i = v[i];
        end
        @(negedge clk_i);
        pll_shift_i = 1'b0;
        pll_update_i = 1'b1;
        @(negedge clk_i);
        pll_update_i = 1'b0;
        @(negedge clk_i);
        chk("pll_mult_o", v[23:16], pll_mult_o);
        chk("pll_div_o", v[15:8], pll_div_o);
        chk("pll_delay_o", v[7:0], pll_delay_o);
        chk("user_mode_o", 8'h01, {7'h00, user_mode_o});
    endtask : pll_load

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : wrap_up

    task automatic sc_boot;
        repeat (8) @(posedge clk_i);
        @(negedge clk_i);
        rst_i = 1'b0;
        repeat (4) @(negedge clk_i);
        chk("io_oe_o", 8'h00, {7'h00, io_oe_o});
        chk("cfg_ready_o", 8'h00, {7'h00, cfg_ready_o});
        chk("ceo", 8'h01, {7'h00, chain_enable_out_n_o});
        chain_enable_in_n_i = 1'b0;
        to_user(3'h0);
        chk("factory_o", 8'h01, {7'h00, factory_o});
        wr_ctrl(3'h2, 1'b1, 2'h1);
        repeat (40) @(negedge clk_i);
        chk("user_mode_o", 8'h01, {7'h00, user_mode_o});
    endtask : sc_boot

    task automatic sc_app;
        scheme_i = 3'h2;
        slow = 1'b1;
        wdt_kick_i = 1'b1;
        fire(1'b0);
        reboot(4'h8, 3'h0, 3'h2);
        to_user(3'h2);
        chk("factory_o", 8'h00, {7'h00, factory_o});
        pll_load(24'h3C5A96);
    endtask : sc_app

    task automatic sc_wdt;
        int n;
        n = 0;
        wdt_kick_i = 1'b0;
        while (user_mode_o === 1'b1 && n < 40) begin
            @(negedge clk_i);
            n++;
        end
        // select 1 gives 16 cycles, plus one to reconfigure
        chk("wdt cycles", 8'h11, n[7:0]);
        reboot(4'h2, 3'h2, 3'h0);
        slow = 1'b0;
        scheme_i = 3'h3;
        to_user(3'h0);
    endtask : sc_wdt

    task automatic sc_err;
        int n;
        n = 0;
        wr_ctrl(3'h7, 1'b0, 2'h0);
        err_page = 4'h7;
        fire(1'b0);
        while (status_cause_o !== 4'h4 && n < 100) begin
            @(negedge clk_i);
            n++;
        end
        reboot(4'h4, 3'h7, 3'h0);
        to_user(3'h0);
        err_page = 4'hF;
    endtask : sc_err

    task automatic sc_pin;
        fire(1'b1);
        reboot(4'h1, 3'h0, 3'h7);
        to_user(3'h7);
        fire(1'b1);
        reboot(4'h1, 3'h7, 3'h0);
        to_user(3'h0);
    endtask : sc_pin

    task automatic sc_local;
        @(negedge clk_i);
        rst_i = 1'b1;
        remote_mode_i = 1'b0;
        repeat (8) @(negedge clk_i);
        chk("io_oe_o", 8'h00, {7'h00, io_oe_o});
        rst_i = 1'b0;
        to_user(3'h1);
        chk("factory_o", 8'h00, {7'h00, factory_o});
        for (int s = 0; s < 5; s++) begin
            scheme_i = s[2:0];
            fire(1'b1);
            reboot(4'h1, 3'h1, 3'h1);
            to_user(3'h1);
        end
    endtask : sc_local

    initial begin
        fork
            begin
                sc_boot();
                sc_app();
                sc_wdt();
                sc_err();
                sc_pin();
                sc_local();
            end
            begin
                repeat (8000) @(posedge clk_i);
                chk("timeout", 8'h00, 8'h01);
            end
        join_any
        wrap_up();
    end
endmodule : remote_update_config_loader_test
